// ### hdl/chgi2c_consts.svh
`ifndef CHGI2C_CONSTS_SVH
`define CHGI2C_CONSTS_SVH
// What this block does
// RULE_01 - slave only, 100k and 400k, same protocol
// RULE_02 - seven-bit address 0x6a, write byte 0xd4
// RULE_03 - sda stuck low too long resets engine
// RULE_04 - stuck timer restarts on start, stops at stop
// RULE_05 - address match acks whole ninth clock high
// RULE_06 - direction bit 0 writes, 1 reads
// RULE_07 - receiver acks every byte, bytes repeat freely
// RULE_08 - stop releases bus, await start and address
// RULE_09 - master ends any abandoned transfer with stop
// RULE_10 - unmapped register reads return 0xff
// RULE_11 - host waits for regulated rail first
// RULE_12 - status bits 7:6 give live charge state
// RULE_13 - status bit 5 write-only ship request
// RULE_14 - status bit 4 reset fault, read clears
// RULE_15 - status bit 3 timer fault, pin toggle clears
// RULE_16 - status bits 2:0 live power, pin, switcher
// RULE_17 - fault bit 7 overvoltage, stays while present
// RULE_18 - fault bit 6 undervoltage, once per event
// RULE_19 - fault bit 5 battery lockout, stays while present
// RULE_20 - fault bit 4 battery overcurrent, read clears
// RULE_21 - fault bits 3:0 masks, reset zero
// RULE_22 - fault state without flags means current limit
// RULE_23 - overvoltage sets flag, fault state, interrupt
// RULE_24 - first written byte selects register for reads

`define CHGI2C_CLK_NS      25
`define CHGI2C_STD_NS      10000
`define CHGI2C_FAST_NS     2500
`define CHGI2C_QTR_STD     ((`CHGI2C_STD_NS / 4) / `CHGI2C_CLK_NS)
`define CHGI2C_QTR_FAST    ((`CHGI2C_FAST_NS / 4) / `CHGI2C_CLK_NS)
`define CHGI2C_STUCK_MS    50
`define CHGI2C_STUCK_CYC   ((`CHGI2C_STUCK_MS * 1000000) / `CHGI2C_CLK_NS)

`define CHGI2C_DEV_ADDR    7'h6a
`define CHGI2C_REG_STAT    8'h00
`define CHGI2C_REG_FLT     8'h01
`define CHGI2C_UNMAPPED    8'hff
`define CHGI2C_SHIP_BIT    5
`define CHGI2C_MASK_RST    4'h0

`define CHGI2C_H_PTR       3'h0
`define CHGI2C_H_WDATA     3'h1
`define CHGI2C_H_CTRL      3'h2
`define CHGI2C_H_STAT      3'h3
`define CHGI2C_H_RDATA     3'h4
`endif

// ### hdl/chgi2c_pkg.sv
package chgi2c_pkg;
  typedef enum logic [1:0] {
    CHGI2C_READY = 2'b00,
    CHGI2C_CHARGING = 2'b01,
    CHGI2C_DONE = 2'b10,
    CHGI2C_FAULT = 2'b11
  } chgi2c_chg_t;

  typedef enum logic [2:0] {
    D_IDLE = 3'b000,
    D_ADDR = 3'b001,
    D_AACK = 3'b010,
    D_WR   = 3'b011,
    D_WACK = 3'b100,
    D_RD   = 3'b101,
    D_RACK = 3'b110
  } chgi2c_dst_t;

  typedef enum logic [1:0] {
    H_IDLE  = 2'b00,
    H_START = 2'b01,
    H_XFER  = 2'b10,
    H_STOP  = 2'b11
  } chgi2c_hst_t;

  typedef enum logic [1:0] {
    OP_START = 2'b00,
    OP_SEND  = 2'b01,
    OP_RECV  = 2'b10,
    OP_STOP  = 2'b11
  } chgi2c_op_t;
endpackage

// ### hdl/chgi2c_if.sv
`timescale 1ns/10ps
interface chgi2c_if;
  logic scl_o;
  logic scl_oe_n;
  logic sda_h_o;
  logic sda_h_oe_n;
  logic sda_d_o;
  logic sda_d_oe_n;
  logic scl;
  logic sda;

  // open-drain wires with pull-ups
  assign scl = scl_oe_n | scl_o;
  assign sda = (sda_h_oe_n | sda_h_o) & (sda_d_oe_n | sda_d_o);

  modport dev (input scl, input sda, output sda_d_o, output sda_d_oe_n);
  modport host (input scl, input sda, output scl_o, output scl_oe_n,
                output sda_h_o, output sda_h_oe_n);
endinterface

// ### hdl/chgi2c_dev.sv
`timescale 1ns/10ps
`include "chgi2c_consts.svh"
module chgi2c_dev #(
  parameter int STUCK_CYC = `CHGI2C_STUCK_CYC
) (
  // clock and reset
  input  wire logic                     clk_i,
  input  wire logic                     srst_i,
  // two-wire link
  chgi2c_if.dev                         bus,
  // charger status inputs
  input  wire chgi2c_pkg::chgi2c_chg_t  charge_state_i,
  input  wire logic                     input_power_mgmt_active_i,
  input  wire logic                     disable_pin_i,
  input  wire logic                     switcher_on_i,
  input  wire logic                     later_fault_i,
  // fault conditions and events
  input  wire logic                     pb_reset_evt_i,
  input  wire logic                     safety_timer_evt_i,
  input  wire logic                     vin_over_i,
  input  wire logic                     vin_under_i,
  input  wire logic                     bat_lockout_i,
  input  wire logic                     bat_overcurrent_evt_i,
  // outputs to the charger
  output logic                          ship_mode_request_o,
  output logic                          int_o,
  output logic                          input_current_limit_o
);
  import chgi2c_pkg::*;

  logic [1:0]  sy1_r, sy2_r, sy3_r, ln_r, lnq_r;
  logic        scl, sda, scl_rise, scl_fall, start_c, stop_c;
  chgi2c_dst_t st_r;
  logic [3:0]  cnt_r;
  logic [7:0]  sh_r, ptr_r;
  logic        rw_r, first_r, mack_r, oe_n_r, active_r, tout;
  logic [31:0] stuck_r;
  logic        wr_evt, ld_evt, rd_stat, rd_flt;
  logic        ship_r, rst_flt_r, tmr_flt_r, ov_r, uv_r, uvlo_r, ocp_r;
  logic [3:0]  mask_r;
  logic        cd_q_r, uv_q_r, ov_q_r, uvlo_q_r, int_r, input_current_limit_r;
  logic [1:0]  chg_field;
  logic [7:0]  stat_byte, flt_byte;

  // both sampled lines pass three flops; value taken when 2nd and 3rd agree
  always_ff @(posedge clk_i) begin
    sy1_r <= {bus.scl, bus.sda};
    sy2_r <= sy1_r;
    sy3_r <= sy2_r;
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ln_r  <= 2'b11;
      lnq_r <= 2'b11;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (sy2_r[i] == sy3_r[i]) begin
          ln_r[i] <= sy3_r[i];
        end
      end
      lnq_r <= ln_r;
    end
  end

  assign scl      = ln_r[1];
  assign sda      = ln_r[0];
  assign scl_rise = scl & ~lnq_r[1];
  assign scl_fall = ~scl & lnq_r[1];
  assign start_c  = scl & lnq_r[1] & lnq_r[0] & ~sda;
  // RULE_08 stop detection
  assign stop_c   = scl & lnq_r[1] & ~lnq_r[0] & sda;

  // RULE_04 timer start and stop
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      active_r <= 1'b0;
      stuck_r  <= 32'h0;
    end else if (start_c) begin
      active_r <= 1'b1;
      stuck_r  <= 32'h0;
    end else if (stop_c || tout) begin
      active_r <= 1'b0;
      stuck_r  <= 32'h0;
    end else if (active_r && !sda) begin
      stuck_r  <= stuck_r + 32'h1;
    end else begin
      stuck_r  <= 32'h0;
    end
  end

  // RULE_03 stuck low detection
  assign tout = active_r & ~sda & (stuck_r >= 32'(STUCK_CYC - 1));

  assign wr_evt = (st_r == D_WR) & scl_fall & (cnt_r == 4'h8);
  assign ld_evt = scl_fall & (((st_r == D_AACK) & rw_r) |
                              ((st_r == D_RACK) & ~mack_r));
  assign rd_stat = ld_evt & (ptr_r == `CHGI2C_REG_STAT);
  assign rd_flt  = ld_evt & (ptr_r == `CHGI2C_REG_FLT);

  function automatic logic [7:0] rd_mux(input logic [7:0] p,
                                        input logic [7:0] s,
                                        input logic [7:0] f);
    if (p == `CHGI2C_REG_STAT) begin
      rd_mux = s;
    end else if (p == `CHGI2C_REG_FLT) begin
      rd_mux = f;
    end else begin
      // RULE_10 unmapped read value
      rd_mux = `CHGI2C_UNMAPPED;
    end
  endfunction

  // RULE_01 one engine for both rates, slave only
  always_ff @(posedge clk_i) begin
    if (srst_i || tout || stop_c) begin
      // RULE_03 engine reset releases sda
      st_r    <= D_IDLE;
      cnt_r   <= 4'h0;
      oe_n_r  <= 1'b1;
      first_r <= 1'b0;
    end else if (start_c) begin
      st_r    <= D_ADDR;
      cnt_r   <= 4'h0;
      oe_n_r  <= 1'b1;
    end else if (scl_rise) begin
      case (st_r)
        D_ADDR, D_WR: begin
          sh_r  <= {sh_r[6:0], sda};
          cnt_r <= cnt_r + 4'h1;
        end
        D_RD: begin
          cnt_r <= cnt_r + 4'h1;
        end
        D_RACK: begin
          mack_r <= sda;
        end
        default: begin
        end
      endcase
    end else if (scl_fall) begin
      case (st_r)
        D_ADDR: begin
          if (cnt_r == 4'h8) begin
            // RULE_02 RULE_05 ack only own address
            if (sh_r[7:1] == `CHGI2C_DEV_ADDR) begin
              st_r   <= D_AACK;
              oe_n_r <= 1'b0;
              // RULE_06 direction bit
              rw_r   <= sh_r[0];
            end else begin
              st_r <= D_IDLE;
            end
          end
        end
        D_AACK: begin
          cnt_r <= 4'h0;
          if (rw_r) begin
            sh_r   <= rd_mux(ptr_r, stat_byte, flt_byte);
            oe_n_r <= rd_mux(ptr_r, stat_byte, flt_byte) >> 7 != 8'h0;
            st_r   <= D_RD;
          end else begin
            oe_n_r  <= 1'b1;
            first_r <= 1'b1;
            st_r    <= D_WR;
          end
        end
        D_WR: begin
          if (cnt_r == 4'h8) begin
            // RULE_07 device acks each received byte
            oe_n_r <= 1'b0;
            st_r   <= D_WACK;
          end
        end
        D_WACK: begin
          oe_n_r  <= 1'b1;
          first_r <= 1'b0;
          cnt_r   <= 4'h0;
          st_r    <= D_WR;
        end
        D_RD: begin
          if (cnt_r == 4'h8) begin
            oe_n_r <= 1'b1;
            st_r   <= D_RACK;
          end else begin
            oe_n_r <= sh_r[6];
            sh_r   <= {sh_r[6:0], 1'b1};
          end
        end
        D_RACK: begin
          cnt_r <= 4'h0;
          // RULE_07 master ack continues the read
          if (!mack_r) begin
            sh_r   <= rd_mux(ptr_r, stat_byte, flt_byte);
            oe_n_r <= rd_mux(ptr_r, stat_byte, flt_byte) >> 7 != 8'h0;
            st_r   <= D_RD;
          end else begin
            st_r <= D_IDLE;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // RULE_24 first data byte selects register
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ptr_r <= `CHGI2C_REG_STAT;
    end else if (wr_evt && first_r) begin
      ptr_r <= sh_r;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ship_r <= 1'b0;
      mask_r <= `CHGI2C_MASK_RST;
    end else if (wr_evt && !first_r) begin
      if (ptr_r == `CHGI2C_REG_STAT) begin
        // RULE_13 ship request
        ship_r <= sh_r[`CHGI2C_SHIP_BIT];
      end else if (ptr_r == `CHGI2C_REG_FLT) begin
        // RULE_21 mask write
        mask_r <= sh_r[3:0];
      end
    end
  end

  // set beats a clearing read in the same cycle
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rst_flt_r <= 1'b0;
      tmr_flt_r <= 1'b0;
      ov_r      <= 1'b0;
      uv_r      <= 1'b0;
      uvlo_r    <= 1'b0;
      ocp_r     <= 1'b0;
    end else begin
      // RULE_14 read clears reset fault
      rst_flt_r <= pb_reset_evt_i | (rst_flt_r & ~rd_stat);
      // RULE_15 only a pin toggle clears
      tmr_flt_r <= safety_timer_evt_i |
                   (tmr_flt_r & (disable_pin_i == cd_q_r));
      // RULE_17 RULE_21 persists while present
      ov_r   <= (vin_over_i & ~mask_r[3]) | (ov_r & ~rd_flt);
      // RULE_18 once per falling-input event
      uv_r   <= (vin_under_i & ~uv_q_r & ~mask_r[2]) | (uv_r & ~rd_flt);
      // RULE_19 persists while lockout holds
      uvlo_r <= (bat_lockout_i & ~mask_r[1]) | (uvlo_r & ~rd_flt);
      // RULE_20 read clears overcurrent
      ocp_r  <= (bat_overcurrent_evt_i & ~mask_r[0]) | (ocp_r & ~rd_flt);
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cd_q_r   <= 1'b0;
      uv_q_r   <= 1'b0;
      ov_q_r   <= 1'b0;
      uvlo_q_r <= 1'b0;
    end else begin
      cd_q_r   <= disable_pin_i;
      uv_q_r   <= vin_under_i;
      ov_q_r   <= vin_over_i;
      uvlo_q_r <= bat_lockout_i;
    end
  end

  // RULE_12 RULE_23 live state, forced to fault on overvoltage
  assign chg_field = vin_over_i ? CHGI2C_FAULT : charge_state_i;
  // RULE_16 live status bits, write-only bit reads zero
  assign stat_byte = {chg_field, 1'b0, rst_flt_r, tmr_flt_r,
                      input_power_mgmt_active_i, disable_pin_i,
                      switcher_on_i};
  assign flt_byte  = {ov_r, uv_r, uvlo_r, ocp_r, mask_r};

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      int_r  <= 1'b0;
      input_current_limit_r <= 1'b0;
    end else begin
      // RULE_23 interrupt pulse on unmasked new fault
      int_r  <= (vin_over_i & ~ov_q_r & ~mask_r[3]) |
                (vin_under_i & ~uv_q_r & ~mask_r[2]) |
                (bat_lockout_i & ~uvlo_q_r & ~mask_r[1]) |
                (bat_overcurrent_evt_i & ~mask_r[0]);
      // RULE_22 unexplained fault state
      input_current_limit_r <= (chg_field == CHGI2C_FAULT) & ~(ov_r | uv_r | uvlo_r |
                ocp_r | tmr_flt_r | later_fault_i);
    end
  end

  assign bus.sda_d_o      = 1'b0;
  assign bus.sda_d_oe_n   = oe_n_r;
  assign ship_mode_request_o   = ship_r;
  assign int_o                 = int_r;
  assign input_current_limit_o = input_current_limit_r;
endmodule

// ### hdl/chgi2c_host.sv
`timescale 1ns/10ps
`include "chgi2c_consts.svh"
module chgi2c_host (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        srst_i,
  // two-wire link
  chgi2c_if.host           bus,
  // software port
  input  wire logic [2:0]  addr_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [7:0]  rdata_o,
  // system
  input  wire logic        regulated_rail_up_i
);
  import chgi2c_pkg::*;

  logic [1:0]  sy1_r, sy2_r, sy3_r, ln_r;
  chgi2c_hst_t st_r;
  chgi2c_op_t  nop;
  logic [2:0]  seg_r, nseg;
  logic [1:0]  q_r;
  logic [3:0]  bit_r;
  logic [7:0]  div_r, ptr_r, wd_r, rx_byte_r, rdo_r, nbyte;
  logic [8:0]  sh_r, rx_r;
  logic        rw_r, fast_r, nack_r, done_r, recv_r;
  logic        scl_oe_n_r, sda_oe_n_r, tick;

  function automatic chgi2c_op_t seg_op(input logic [2:0] s,
                                        input logic rw);
    if (s == 3'h0 || (rw && s == 3'h3)) begin
      seg_op = OP_START;
    end else if (rw && s == 3'h5) begin
      seg_op = OP_RECV;
    end else if ((!rw && s >= 3'h4) || (rw && s >= 3'h6)) begin
      seg_op = OP_STOP;
    end else begin
      seg_op = OP_SEND;
    end
  endfunction

  always_ff @(posedge clk_i) begin
    sy1_r <= {bus.scl, bus.sda};
    sy2_r <= sy1_r;
    sy3_r <= sy2_r;
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ln_r <= 2'b11;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (sy2_r[i] == sy3_r[i]) begin
          ln_r[i] <= sy3_r[i];
        end
      end
    end
  end

  assign nseg  = seg_r + 3'h1;
  assign nop   = seg_op(nseg, rw_r);
  // RULE_02 RULE_06 address with direction bit
  assign nbyte = (nseg == 3'h1) ? {`CHGI2C_DEV_ADDR, 1'b0} :
                 (nseg == 3'h2) ? ptr_r :
                 (nseg == 3'h4) ? {`CHGI2C_DEV_ADDR, 1'b1} :
                 rw_r ? 8'hff : wd_r;
  // a device holding scl low stalls the quarter timer
  assign tick  = (div_r == 8'h0) & ~(scl_oe_n_r & ~ln_r[1]);

  always_ff @(posedge clk_i) begin
    if (srst_i || st_r == H_IDLE) begin
      div_r <= 8'h0;
    end else if (tick) begin
      div_r <= fast_r ? 8'(`CHGI2C_QTR_FAST - 1) :
                        8'(`CHGI2C_QTR_STD - 1);
    end else if (div_r != 8'h0) begin
      div_r <= div_r - 8'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      st_r       <= H_IDLE;
      q_r        <= 2'h0;
      seg_r      <= 3'h0;
      scl_oe_n_r <= 1'b1;
      sda_oe_n_r <= 1'b1;
      nack_r     <= 1'b0;
      done_r     <= 1'b0;
    end else if (st_r == H_IDLE) begin
      // RULE_11 refuse start until rail is up
      if (wr_i && addr_i == `CHGI2C_H_CTRL && wdata_i[0] &&
          regulated_rail_up_i) begin
        st_r   <= H_START;
        seg_r  <= 3'h0;
        q_r    <= 2'h0;
        rw_r   <= wdata_i[1];
        fast_r <= wdata_i[2];
        nack_r <= 1'b0;
        done_r <= 1'b0;
      end
    end else if (tick) begin
      q_r <= q_r + 2'h1;
      case (st_r)
        H_START: begin
          case (q_r)
            2'h0: sda_oe_n_r <= 1'b1;
            2'h1: scl_oe_n_r <= 1'b1;
            2'h2: sda_oe_n_r <= 1'b0;
            default: begin
              scl_oe_n_r <= 1'b0;
              seg_r      <= nseg;
              st_r       <= H_XFER;
              sh_r       <= {nbyte, 1'b1};
              recv_r     <= (nop == OP_RECV);
              bit_r      <= 4'h0;
            end
          endcase
        end
        H_XFER: begin
          case (q_r)
            2'h0: sda_oe_n_r <= sh_r[8];
            2'h1: scl_oe_n_r <= 1'b1;
            2'h2: rx_r <= {rx_r[7:0], ln_r[0]};
            default: begin
              scl_oe_n_r <= 1'b0;
              sh_r       <= {sh_r[7:0], 1'b1};
              bit_r      <= bit_r + 4'h1;
              if (bit_r == 4'h8) begin
                if (recv_r) begin
                  rx_byte_r <= rx_r[8:1];
                end
                // RULE_09 stop after a refused byte
                if (!recv_r && rx_r[0]) begin
                  nack_r <= 1'b1;
                  st_r   <= H_STOP;
                end else if (nop == OP_START) begin
                  // step onto the restart segment; the start sequence then loads the read address
                  seg_r <= nseg;
                  st_r  <= H_START;
                end else if (nop == OP_STOP) begin
                  st_r <= H_STOP;
                end else begin
                  // RULE_07 next nine-bit unit
                  seg_r  <= nseg;
                  sh_r   <= {nbyte, 1'b1};
                  recv_r <= (nop == OP_RECV);
                  bit_r  <= 4'h0;
                end
              end
            end
          endcase
        end
        default: begin
          case (q_r)
            2'h0: sda_oe_n_r <= 1'b0;
            2'h1: scl_oe_n_r <= 1'b1;
            2'h2: sda_oe_n_r <= 1'b1;
            default: begin
              st_r   <= H_IDLE;
              done_r <= 1'b1;
            end
          endcase
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ptr_r <= 8'h0;
      wd_r  <= 8'h0;
      rdo_r <= 8'h0;
    end else begin
      if (wr_i && addr_i == `CHGI2C_H_PTR) begin
        ptr_r <= wdata_i;
      end
      if (wr_i && addr_i == `CHGI2C_H_WDATA) begin
        wd_r <= wdata_i;
      end
      if (!rd_i) begin
        rdo_r <= 8'h0;
      end else if (addr_i == `CHGI2C_H_PTR) begin
        rdo_r <= ptr_r;
      end else if (addr_i == `CHGI2C_H_WDATA) begin
        rdo_r <= wd_r;
      end else if (addr_i == `CHGI2C_H_STAT) begin
        rdo_r <= {4'h0, regulated_rail_up_i, done_r, nack_r,
                  st_r != H_IDLE};
      end else if (addr_i == `CHGI2C_H_RDATA) begin
        rdo_r <= rx_byte_r;
      end else begin
        rdo_r <= 8'h0;
      end
    end
  end

  assign bus.scl_o      = 1'b0;
  assign bus.scl_oe_n   = scl_oe_n_r;
  assign bus.sda_h_o    = 1'b0;
  assign bus.sda_h_oe_n = sda_oe_n_r;
  assign rdata_o        = rdo_r;
endmodule

// ### verification/chgi2c_monitor.sv
`timescale 1ns/10ps
`include "chgi2c_consts.svh"
module chgi2c_monitor #(
  parameter int STUCK_CYC = `CHGI2C_STUCK_CYC
) (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic srst_i,
  // link signals
  input  wire logic scl_o,
  input  wire logic scl_oe_n,
  input  wire logic sda_h_o,
  input  wire logic sda_h_oe_n,
  input  wire logic sda_d_o,
  input  wire logic sda_d_oe_n,
  input  wire logic scl,
  input  wire logic sda
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  logic       scl_q_r;
  logic       sda_q_r;
  logic       first_r;
  logic       dir_r;
  logic       match_r;
  logic [3:0] cnt_r;
  logic [7:0] sh_r;
  logic       rise;
  logic       start;
  logic       stop;
  logic [31:0] low_r;

  // idle level after reset keeps false edges away
  always_ff @(posedge clk_i) begin
    scl_q_r <= srst_i | scl;
    sda_q_r <= srst_i | sda;
  end
  assign rise  = scl & ~scl_q_r;
  assign start = scl & scl_q_r & sda_q_r & ~sda;
  assign stop  = scl & scl_q_r & ~sda_q_r & sda;

  // low data run; past the stuck limit the device may drop the transfer
  always_ff @(posedge clk_i) begin
    if (srst_i || sda) begin
      low_r <= 32'h0;
    end else begin
      low_r <= low_r + 32'h1;
    end
  end

  // bit position within the nine-bit unit
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cnt_r   <= 4'h0;
      first_r <= 1'b0;
      dir_r   <= 1'b0;
      match_r <= 1'b0;
    end else if (start) begin
      cnt_r   <= 4'h0;
      first_r <= 1'b1;
    end else if (stop || low_r == 32'(STUCK_CYC)) begin
      first_r <= 1'b0;
      match_r <= 1'b0;
    end else if (rise) begin
      cnt_r <= (cnt_r == 4'h8) ? 4'h0 : cnt_r + 4'h1;
      if (cnt_r == 4'h8 && first_r) begin
        first_r <= 1'b0;
        dir_r   <= sh_r[0];
        match_r <= sh_r[7:1] == `CHGI2C_DEV_ADDR;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rise && cnt_r != 4'h8) begin
      sh_r <= {sh_r[6:0], sda};
    end
  end

  AST_RESET_RELEASED: assert property (
    $fell(srst_i) |-> scl_oe_n && sda_h_oe_n && sda_d_oe_n)
    else $error("link not released after reset");
  AST_OPEN_DRAIN: assert property (
    !scl_o && !sda_h_o && !sda_d_o)
    else $error("open-drain data not low");
  AST_ADDR_ACK: assert property (
    rise && first_r && cnt_r == 4'h8 |->
      sda == (sh_r[7:1] != `CHGI2C_DEV_ADDR))
    else $error("address acknowledge wrong");
  AST_STABLE_HIGH: assert property (
    scl && $past(scl) |-> $stable(sda_d_oe_n))
    else $error("device data moved while clock high");
  AST_WRITE_QUIET: assert property (
    rise && !first_r && !dir_r && cnt_r != 4'h8 |-> sda_d_oe_n)
    else $error("device drove data in a write");
  AST_WRITE_ACK: assert property (
    rise && !first_r && !dir_r && match_r && cnt_r == 4'h8 |-> !sda)
    else $error("written byte not acknowledged");
  AST_READ_MASTER_ACK: assert property (
    rise && !first_r && dir_r && match_r && cnt_r == 4'h8 |-> sda_d_oe_n)
    else $error("device drove master acknowledge slot");
  AST_IDLE_RELEASED: assert property (
    !first_r && !match_r |-> sda_d_oe_n)
    else $error("device drove idle or foreign bus");
  AST_STOP_RELEASE: assert property (
    stop |-> sda_d_oe_n [*8])
    else $error("device drove after stop");
endmodule

// ### verification/tb_chgi2c.sv
`timescale 1ns/10ps
module tb_chgi2c;
  import chgi2c_pkg::*;
  logic        clk_i   = 1'b0;
  logic        srst_i  = 1'b1;
  logic [2:0]  addr_i  = 3'h0;
  logic [7:0]  wdata_i = 8'h00;
  logic        wr_i    = 1'b0;
  logic        rd_i    = 1'b0;
  logic        rail    = 1'b0;
  chgi2c_chg_t chg     = CHGI2C_READY;
  logic        ipm     = 1'b0;
  logic        dis     = 1'b0;
  logic        sw      = 1'b0;
  logic        later   = 1'b0;
  logic        pb      = 1'b0;
  logic        tmr     = 1'b0;
  logic        ov      = 1'b0;
  logic        uv      = 1'b0;
  logic        lock    = 1'b0;
  logic        ocp     = 1'b0;
  logic [7:0]  rdata_o;
  logic        ship;
  logic        irq;
  logic        input_current_limit;
  logic [7:0]  d;
  logic [7:0]  hs_e       = 8'h0c;
  int          mismatches = 0;
  int          n_checks   = 0;
  int          cyc        = 0;
  int          irq_n      = 0;
  int          n0;

  initial forever #12.5 clk_i = ~clk_i;

  chgi2c_if bus_if ();
  chgi2c_host chgi2c_host_i (.clk_i(clk_i), .srst_i(srst_i), .bus(bus_if),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .regulated_rail_up_i(rail));
  // limit above any legal low run, below a zero byte at 100k
  chgi2c_dev #(.STUCK_CYC(3000)) chgi2c_dev_i (.clk_i(clk_i),
    .srst_i(srst_i), .bus(bus_if), .charge_state_i(chg),
    .input_power_mgmt_active_i(ipm), .disable_pin_i(dis),
    .switcher_on_i(sw), .later_fault_i(later), .pb_reset_evt_i(pb),
    .safety_timer_evt_i(tmr), .vin_over_i(ov), .vin_under_i(uv),
    .bat_lockout_i(lock), .bat_overcurrent_evt_i(ocp),
    .ship_mode_request_o(ship), .int_o(irq), .input_current_limit_o(input_current_limit));
  chgi2c_monitor #(.STUCK_CYC(3000)) chgi2c_monitor_i (.clk_i(clk_i),
    .srst_i(srst_i),
    .scl_o(bus_if.scl_o), .scl_oe_n(bus_if.scl_oe_n),
    .sda_h_o(bus_if.sda_h_o), .sda_h_oe_n(bus_if.sda_h_oe_n),
    .sda_d_o(bus_if.sda_d_o), .sda_d_oe_n(bus_if.sda_d_oe_n),
    .scl(bus_if.scl), .sda(bus_if.sda));

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic sw_wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= v;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  task automatic sw_rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(negedge clk_i);
    v = rdata_o;
  endtask

  // one bus transfer; a read leaves the byte in d
  task automatic xfer(input logic [7:0] p, input logic [7:0] w,
                      input logic r, input logic f);
    int k;
    sw_wr(3'h0, p);
    sw_wr(3'h1, w);
    sw_wr(3'h2, {5'h00, f, r, 1'b1});
    k = 0;
    d = 8'h00;
    while (d[2] !== 1'b1 && k < 20000) begin
      sw_rd(3'h3, d);
      k++;
    end
    chk("host status", hs_e, {4'h0, d[3:0]});
    if (r) begin
      sw_rd(3'h4, d);
    end
  endtask

  task automatic rdreg(input logic [7:0] p, input logic [7:0] e,
                       input string nm);
    xfer(p, 8'h00, 1'b1, 1'b1);
    chk(nm, e, d);
  endtask

  always @(posedge clk_i) begin
    if (irq === 1'b1) begin
      irq_n++;
    end
  end

  // ceiling some 12000 cycles above the expected run length of about 83000 cycles
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 95000) begin
      mismatches++;
      report_and_stop();
    end
  end

  initial begin
    repeat (6) @(posedge clk_i);
    srst_i <= 1'b0;
    @(negedge clk_i);
    chk("ship reset", 8'h00, {7'h00, ship});
    chk("irq reset", 8'h00, {7'h00, irq});
    sw_wr(3'h2, 8'h01);
    sw_rd(3'h3, d);
    chk("go refused", 8'h00, {7'h00, d[0]});
    rail <= 1'b1;
    $display("reset test done");
    xfer(8'h00, 8'h20, 1'b0, 1'b1);
    chk("ship on", 8'h01, {7'h00, ship});
    hs_e = 8'h0e;
    xfer(8'h00, 8'h00, 1'b0, 1'b0);
    hs_e = 8'h0c;
    chk("ship kept", 8'h01, {7'h00, ship});
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_i);
      chg <= chgi2c_chg_t'(i[1:0]);
      ipm <= i[0];
      dis <= i[1];
      sw  <= ~i[0];
      rdreg(8'h00, {i[1:0], 3'h0, i[0], i[1], ~i[0]}, "status");
    end
    @(posedge clk_i);
    chg <= CHGI2C_READY;
    dis <= 1'b0;
    sw  <= 1'b0;
    ipm <= 1'b0;
    xfer(8'h00, 8'h00, 1'b0, 1'b1);
    chk("ship off", 8'h00, {7'h00, ship});
    $display("status test done");
    @(posedge clk_i);
    pb  <= 1'b1;
    tmr <= 1'b1;
    @(posedge clk_i);
    pb  <= 1'b0;
    tmr <= 1'b0;
    rdreg(8'h00, 8'h18, "pb timer");
    rdreg(8'h00, 8'h08, "timer kept");
    @(posedge clk_i);
    dis <= 1'b1;
    @(posedge clk_i);
    dis <= 1'b0;
    rdreg(8'h00, 8'h00, "timer cleared");
    $display("status flag test done");
    n0 = irq_n;
    @(posedge clk_i);
    ov   <= 1'b1;
    lock <= 1'b1;
    uv   <= 1'b1;
    ocp  <= 1'b1;
    @(posedge clk_i);
    ocp <= 1'b0;
    rdreg(8'h01, 8'hf0, "faults");
    chk("int raised", 8'h01, {7'h00, irq_n != n0});
    rdreg(8'h00, 8'hc0, "ov state");
    rdreg(8'h01, 8'ha0, "faults kept");
    @(posedge clk_i);
    ov   <= 1'b0;
    lock <= 1'b0;
    uv   <= 1'b0;
    rdreg(8'h01, 8'ha0, "faults latched");
    $display("fault test done");
    xfer(8'h01, 8'h0f, 1'b0, 1'b0);
    n0 = irq_n;
    @(posedge clk_i);
    ov   <= 1'b1;
    lock <= 1'b1;
    uv   <= 1'b1;
    ocp  <= 1'b1;
    @(posedge clk_i);
    ocp <= 1'b0;
    rdreg(8'h01, 8'h0f, "masked");
    chk("int masked", 8'h00, {7'h00, irq_n != n0});
    @(posedge clk_i);
    ov   <= 1'b0;
    lock <= 1'b0;
    uv   <= 1'b0;
    xfer(8'h01, 8'h00, 1'b0, 1'b1);
    $display("mask test done");
    @(posedge clk_i);
    chg <= CHGI2C_FAULT;
    repeat (4) @(negedge clk_i);
    chk("input_current_limit", 8'h01, {7'h00, input_current_limit});
    @(posedge clk_i);
    later <= 1'b1;
    repeat (4) @(negedge clk_i);
    chk("input_current_limit later", 8'h00, {7'h00, input_current_limit});
    $display("limit test done");
    rdreg(8'h02, 8'hff, "unmapped");
    rdreg(8'hff, 8'hff, "unmapped top");
    $display("unmapped test done");
    report_and_stop();
  end
endmodule
